/* File: rtl/motor_irq_pkg.sv */
// package: register map, field positions and reset values of the motor interrupt and ratio block
package motor_irq_pkg;
  localparam logic [1:0] ADDR_WEIGHT = 2'h0;
  localparam logic [1:0] ADDR_PRESCALE = 2'h1;
  localparam logic [1:0] ADDR_ENABLE = 2'h2;
  localparam logic [1:0] ADDR_FLAGS = 2'h3;
  localparam logic [7:0] WEIGHT_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RESYNC_VALUE = 8'hFF;
  localparam logic [3:0] RATIO_MAX = 4'hF;
  localparam logic [3:0] RATIO_MIN = 4'h0;
  localparam int WEIGHT_SHIFT = 8;
  // bit positions shared by enable mask and flags
  localparam int BIT_PWM_UPDATE = 7;
  localparam int BIT_SPEED_ERROR = 6;
  localparam int BIT_RATIO_UP = 6;
  localparam int BIT_RATIO = 5;
  localparam int BIT_RATIO_DOWN = 5;
  localparam int BIT_CURRENT_LIMIT = 4;
  localparam int BIT_EMERGENCY = 3;
  localparam int BIT_ZERO_CROSS = 2;
  localparam int BIT_DEMAG_END = 1;
  localparam int BIT_COMMUTATION = 0;
  localparam logic [1:0] SENSOR_NONE = 2'h0;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic pwm_update;
    logic speed_error;
    logic ratio_up;
    logic ratio_down;
    logic current_limit;
    logic emergency_stop;
    logic zero_cross;
    logic demag_end;
    logic commutation;
  } events_t;

  typedef struct packed {
    logic voltage_current_select;
    logic hw_demag_select;
    logic sim_demag_select;
    logic auto_commutation_select;
    logic capture_select;
    logic [1:0] speed_sensor_select;
  } mode_t;
endpackage

/* File: rtl/motor_irq_regs.sv */
// module: weight, prescaler, interrupt mask and interrupt flag registers of the motor controller
// Function
// - auto mode: zero-cross loads capture times weight/256
// - eight-bit read/write weight register, reset zero
// - upper nibble holds current-mode sampling ratio
// - lower nibble is commutation timer prescale
// - auto or sensor mode: ratio events step the prescale up or down
// - enable mask bit layout, one enables
// - one ratio enable gates both ratio requests
// - current limit interrupt only in voltage mode
// - demag interrupt needs hardware or simulated demag
// - flag register bit layout, one pending
// - pwm update flag set on preload transfer
// - switched: up flag steps ratio, shifts right
// - switched: down flag steps ratio, shifts left
// - auto or sensor mode: ratio flags plain pending
// - writing FFh resyncs pwm and sets update
// - auto mode: software writes other than FFh only clear flags
// - request raised only when flag and enable set
// - resync write leaves other flags untouched
// - commutation select: zero switched, one auto
// - capture select: zero previous, one current capture
`timescale 1ns/1ps
`default_nettype none
module motor_irq_regs
  import motor_irq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  input wire events_t events,
  input wire mode_t mode,
  input wire logic [7:0] current_capture,
  input wire logic [7:0] previous_capture,
  output logic [7:0] next_commutation_compare,
  output logic [3:0] timer_prescale_ratio,
  output logic [3:0] sampling_ratio,
  output logic timer_shift_right,
  output logic timer_shift_left,
  output logic pwm_resync,
  output logic [7:0] irq_request,
  output logic irq
);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic auto_mode;
  logic sensor_mode;
  logic ratio_plain;
  logic wr_weight;
  logic wr_prescale;
  logic wr_enable;
  logic wr_flags;
  logic resync;

  assign auto_mode = mode.auto_commutation_select;
  assign sensor_mode = (mode.speed_sensor_select != SENSOR_NONE);
  assign ratio_plain = auto_mode | sensor_mode;
  assign wr_weight = req.write && (req.addr == ADDR_WEIGHT);
  assign wr_prescale = req.write && (req.addr == ADDR_PRESCALE);
  assign wr_enable = req.write && (req.addr == ADDR_ENABLE);
  assign wr_flags = req.write && (req.addr == ADDR_FLAGS);
  assign resync = wr_flags && (req.wdata == RESYNC_VALUE);

  // ----------------------------------------------------------------
  // weight and multiplier
  // ----------------------------------------------------------------
  logic [7:0] weight_factor_q;
  logic [7:0] mult_operand;
  logic [15:0] product;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      weight_factor_q <= WEIGHT_RESET;
    end else if (wr_weight) begin
      weight_factor_q <= req.wdata;
    end
  end

  assign mult_operand = mode.capture_select ? current_capture : previous_capture;
  assign product = weight_factor_q * mult_operand;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      next_commutation_compare <= 8'h00;
    end else if (auto_mode && events.zero_cross) begin
      next_commutation_compare <= product[15:WEIGHT_SHIFT];
    end
  end

  // ----------------------------------------------------------------
  // prescaler and sampling ratio
  // ----------------------------------------------------------------
  logic [7:0] flags_q;
  logic sw_step_up;
  logic sw_step_down;
  logic step_up;
  logic step_down;

  // switched mode: pending ratio flags act at the next commutation
  assign sw_step_up = !ratio_plain && flags_q[BIT_RATIO_UP] && !flags_q[BIT_RATIO_DOWN]
                      && events.commutation;
  assign sw_step_down = !ratio_plain && flags_q[BIT_RATIO_DOWN] && !flags_q[BIT_RATIO_UP]
                        && events.commutation;
  assign step_up = (ratio_plain && events.ratio_up && !events.ratio_down) || sw_step_up;
  assign step_down = (ratio_plain && events.ratio_down && !events.ratio_up) || sw_step_down;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sampling_ratio <= PRESCALE_RESET[7:4];
    end else if (wr_prescale) begin
      sampling_ratio <= req.wdata[7:4];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_prescale_ratio <= PRESCALE_RESET[3:0];
    end else if (wr_prescale) begin
      timer_prescale_ratio <= req.wdata[3:0];
    end else if (step_up && timer_prescale_ratio != RATIO_MAX) begin
      timer_prescale_ratio <= timer_prescale_ratio + 4'h1;
    end else if (step_down && timer_prescale_ratio != RATIO_MIN) begin
      timer_prescale_ratio <= timer_prescale_ratio - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_shift_right <= 1'b0;
      timer_shift_left <= 1'b0;
    end else begin
      timer_shift_right <= sw_step_up;
      timer_shift_left <= sw_step_down;
    end
  end

  // ----------------------------------------------------------------
  // enable mask
  // ----------------------------------------------------------------
  logic [7:0] enable_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic [7:0] hw_set;
  logic [7:0] flags_d;
  logic [7:0] sw_set_mask;

  always_comb begin
    hw_set = 8'h00;
    hw_set[BIT_PWM_UPDATE] = events.pwm_update || resync;
    hw_set[BIT_RATIO_UP] = ratio_plain && events.ratio_up;
    hw_set[BIT_RATIO_DOWN] = ratio_plain && events.ratio_down;
    hw_set[BIT_CURRENT_LIMIT] = events.current_limit && !mode.voltage_current_select;
    hw_set[BIT_EMERGENCY] = events.emergency_stop;
    hw_set[BIT_ZERO_CROSS] = events.zero_cross;
    hw_set[BIT_DEMAG_END] = events.demag_end;
    hw_set[BIT_COMMUTATION] = events.commutation;
  end

  // in switched mode software may set the two ratio flags
  assign sw_set_mask = ratio_plain ? 8'h00 : 8'h60;

  always_comb begin
    flags_d = flags_q;
    if (wr_flags && !resync) begin
      // zeros clear, ones keep; ratio ones set in switched mode
      flags_d = (flags_q & req.wdata) | (req.wdata & sw_set_mask);
    end
    if (!ratio_plain && events.commutation) begin
      flags_d[BIT_RATIO_UP] = 1'b0;
      flags_d[BIT_RATIO_DOWN] = 1'b0;
    end
    flags_d = flags_d | hw_set;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwm_resync <= 1'b0;
    end else begin
      pwm_resync <= resync;
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  logic [7:0] gate;
  logic demag_ok;

  assign demag_ok = mode.hw_demag_select | mode.sim_demag_select;

  always_comb begin
    gate = enable_q;
    gate[BIT_RATIO_UP] = enable_q[BIT_RATIO] && ratio_plain;
    gate[BIT_RATIO_DOWN] = enable_q[BIT_RATIO] && ratio_plain;
    gate[BIT_CURRENT_LIMIT] = enable_q[BIT_CURRENT_LIMIT] && !mode.voltage_current_select;
    gate[BIT_DEMAG_END] = enable_q[BIT_DEMAG_END] && demag_ok;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_request <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq_request <= flags_d & gate;
      irq <= |(flags_d & gate);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (req.read) begin
      case (req.addr)
        ADDR_WEIGHT: rdata <= weight_factor_q;
        ADDR_PRESCALE: rdata <= {sampling_ratio, timer_prescale_ratio};
        ADDR_ENABLE: rdata <= enable_q;
        ADDR_FLAGS: rdata <= flags_q;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // motor_irq_regs
`default_nettype wire

/* File: tb/motor_irq_regs_asserts.sv */
// checker: port properties of the motor interrupt and ratio registers
`timescale 1ns/1ps
`default_nettype none
module motor_irq_checker
  import motor_irq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire reg_req_t req,
  input wire events_t events,
  input wire mode_t mode,
  input wire logic [7:0] next_commutation_compare,
  input wire logic [3:0] timer_prescale_ratio,
  input wire logic timer_shift_right,
  input wire logic timer_shift_left,
  input wire logic pwm_resync,
  input wire logic [7:0] irq_request
);
  wire logic [3:0] r = timer_prescale_ratio;
  wire logic flag_wr = req.write && req.addr == ADDR_FLAGS;
  wire logic pre_wr = req.write && req.addr == ADDR_PRESCALE;
  wire logic plain = mode.auto_commutation_select || mode.speed_sensor_select != SENSOR_NONE;
  wire logic steps = plain && !pre_wr && (events.ratio_up ^ events.ratio_down);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_resync_pulse: assert property (
    flag_wr && req.wdata == RESYNC_VALUE |=> pwm_resync ##1 !pwm_resync) else $error("no resync");
  a_compare_hold: assert property (
    !$past(events.zero_cross) || !$past(mode.auto_commutation_select)
    |-> $stable(next_commutation_compare)) else $error("compare changed");
  a_ratio_up: assert property (
    steps && events.ratio_up && r != RATIO_MAX |=> r == $past(r) + 4'h1) else $error("no step up");
  a_ratio_down: assert property (
    steps && events.ratio_down && r != RATIO_MIN |=> r == $past(r) - 4'h1) else $error("no step down");
  a_shift_right: assert property (
    timer_shift_right |-> $past(events.commutation) && !timer_shift_left) else $error("stray shift");
  a_shift_left: assert property (
    timer_shift_left |-> $past(events.commutation) && !$past(mode.auto_commutation_select))
    else $error("stray left shift");
  a_current_limit_enable_voltage: assert property (
    events.current_limit && mode.voltage_current_select && !req.write
    |=> !irq_request[4]) else $error("current limit in current mode");
  a_auto_no_set: assert property (
    flag_wr && req.wdata == 8'h7F && mode.auto_commutation_select && events == '0
    |=> irq_request == ($past(irq_request) & 8'h7F)) else $error("flag set by write");
  c_shift_left: cover property (timer_shift_left);
  c_resync: cover property (pwm_resync);
  c_auto_load: cover property (events.zero_cross && mode.auto_commutation_select);
endmodule // motor_irq_checker
bind motor_irq_regs motor_irq_checker i_checker (.clock(clock), .reset_n(reset_n), .req(req),
  .events(events), .mode(mode), .next_commutation_compare(next_commutation_compare),
  .timer_prescale_ratio(timer_prescale_ratio), .timer_shift_right(timer_shift_right),
  .timer_shift_left(timer_shift_left), .pwm_resync(pwm_resync), .irq_request(irq_request));
`default_nettype wire

/* File: tb/motor_irq_regs_tb_top.sv */
// testbench: register, ratio and interrupt checks of the motor interrupt block
`timescale 1ns/1ps
`default_nettype none
module motor_irq_regs_tb_top
  import motor_irq_pkg::*;
();
  localparam events_t ZC = 9'h004, CM = 9'h001, CL = 9'h010, UP = 9'h040, DN = 9'h020;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t req = '0;
  events_t events = '0;
  mode_t mode = '0;
  logic [7:0] cur = 8'h00, prev = 8'h00, rdata, ncc, irqs, w, d;
  logic [3:0] ratio, samp;
  logic shr, shl, sync, irq;
  int failures = 0, total_checks = 0, seed = 31154;
  motor_irq_regs i_motor_irq_regs (.clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
    .events(events), .mode(mode), .current_capture(cur), .previous_capture(prev),
    .next_commutation_compare(ncc), .timer_prescale_ratio(ratio), .sampling_ratio(samp),
    .timer_shift_right(shr), .timer_shift_left(shl), .pwm_resync(sync), .irq_request(irqs),
    .irq(irq));
  initial forever #5 clock = ~clock;
  function automatic logic [7:0] mul(input logic [7:0] a, input logic [7:0] b);
    return 8'((16'(a) * b) >> 8);
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    req <= {a, v, 2'b10};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= {a, 8'h00, 2'b01};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
    check("rdata", rdata, e);
  endtask
  // mode settles one edge ahead of the event pulse
  task automatic fire(input events_t e, input mode_t m);
    @(posedge clock);
    mode <= m;
    @(posedge clock);
    events <= e;
    @(posedge clock);
    events <= '0;
    @(negedge clock);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      wr(ADDR_PRESCALE, d);
      check("prescale", {samp, ratio}, d);
      wr(ADDR_ENABLE, d);
      rd(ADDR_ENABLE, d);
    end
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'hFF : 8'($random(seed));
      wr(ADDR_WEIGHT, w);
      rd(ADDR_WEIGHT, w);
      @(posedge clock);
      cur <= 8'($random(seed));
      prev <= (i == 0) ? 8'hFF : 8'($random(seed));
      fire(ZC, i[0] ? 7'h0C : 7'h08);
      check("compare", ncc, mul(w, i[0] ? cur : prev));
    end
    $display("compare done");
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_ENABLE, 8'h20);
    wr(ADDR_PRESCALE, 8'h5D);
    fire(UP, 7'h08);
    fire(UP, 7'h08);
    check("ratio", {samp, ratio}, 8'h5F);
    check("irq_request", irqs, 8'h40);
    check("irq", {7'h00, irq}, 8'h01);
    wr(ADDR_FLAGS, 8'hBF);
    fire(DN, 7'h0B);
    check("irq_request", irqs, 8'h20);
    wr(ADDR_FLAGS, 8'h7F);
    rd(ADDR_FLAGS, 8'h20);
    check("ratio", {samp, ratio}, 8'h5E);
    fire(ZC, 7'h08);
    wr(ADDR_FLAGS, RESYNC_VALUE);
    check("resync", {7'h00, sync}, 8'h01);
    rd(ADDR_FLAGS, 8'hA4);
    wr(ADDR_FLAGS, 8'h00);
    fire(9'h100, 7'h08);
    rd(ADDR_FLAGS, 8'h80);
    wr(ADDR_FLAGS, 8'h00);
    fire(CL, 7'h48);
    rd(ADDR_FLAGS, 8'h00);
    fire(CL, 7'h08);
    rd(ADDR_FLAGS, 8'h10);
    $display("flags done");
    wr(ADDR_PRESCALE, 8'h37);
    fire('0, 7'h00);
    wr(ADDR_FLAGS, 8'h9F);
    wr(ADDR_FLAGS, 8'hDF);
    fire(CM, 7'h00);
    check("shift_right", {7'h00, shr}, 8'h01);
    check("ratio", {samp, ratio}, 8'h38);
    wr(ADDR_FLAGS, 8'hBF);
    fire(CM, 7'h00);
    check("shift_left", {7'h00, shl}, 8'h01);
    check("ratio", {samp, ratio}, 8'h37);
    fire(ZC, 7'h04);
    check("compare", ncc, mul(w, prev));
    wr(ADDR_ENABLE, 8'h02);
    fire(9'h002, 7'h00);
    check("irq_request", irqs, 8'h00);
    fire(9'h002, 7'h20);
    check("irq_request", irqs, 8'h02);
    $display("switched done");
    summarize;
  end
endmodule // motor_irq_regs_tb_top
`default_nettype wire
